// ===== sfcb_pkg.sv
// constants shared by the synthesiser word and bandwidth configuration slice
package sfcb_pkg;
    // register port geometry
    localparam int          ADDR_W        = 6;
    localparam int          DATA_W        = 8;

    // register offsets
    localparam logic [5:0]  OFF_HIGH      = 6'h0D;
    localparam logic [5:0]  OFF_MIDDLE    = 6'h0E;
    localparam logic [5:0]  OFF_LOW       = 6'h0F;
    localparam logic [5:0]  OFF_BW_RATE   = 6'h10;

    // field positions inside the modem configuration byte and the high word byte
    localparam int          BW_E_LSB      = 6;
    localparam int          BW_M_LSB      = 4;
    localparam int          RATE_E_LSB    = 0;
    localparam int          HIGH_FIX_LSB  = 6;

    // fixed pattern and reset values
    localparam logic [1:0]  HIGH_FIXED    = 2'h1;
    localparam logic [5:0]  HIGH_RESET    = 6'h1E;
    localparam logic [7:0]  MIDDLE_RESET  = 8'hC4;
    localparam logic [7:0]  LOW_RESET     = 8'hEC;
    localparam logic [1:0]  BW_E_RESET    = 2'h2;
    localparam logic [1:0]  BW_M_RESET    = 2'h0;
    localparam logic [3:0]  RATE_E_RESET  = 4'hC;

    // arithmetic constants of the rate and decimation terms
    localparam logic [8:0]  MANT_HIDDEN   = 9'h100;
    localparam logic [8:0]  DECIM_BASE    = 9'h004;
    localparam int          DECIM_SHIFT   = 3;
endpackage : sfcb_pkg

// ===== sfcb_cfg_if.sv
// carrier between the register slice and the rate calculator
`timescale 1ns/1ps
interface sfcb_cfg_if;
    logic [1:0]  bw_e;
    logic [1:0]  bw_m;
    logic [3:0]  rate_e;
    logic [7:0]  rate_m;
    logic [8:0]  decim_ratio;
    logic [23:0] rate_step;

    modport regs (output bw_e, output bw_m, output rate_e, output rate_m,
                  input decim_ratio, input rate_step);
    modport calc (input bw_e, input bw_m, input rate_e, input rate_m,
                  output decim_ratio, output rate_step);
endinterface : sfcb_cfg_if

// ===== sfcb_rate_calc.sv
// decimation ratio and symbol-rate step derived from the configuration fields
`timescale 1ns/1ps
module sfcb_rate_calc (
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    input  wire logic   cen_i,
    sfcb_cfg_if.calc    cfg
);
    typedef struct packed {
        logic [8:0]  decim;
        logic [23:0] step;
    } sfcb_calc_state_t;

    sfcb_calc_state_t state_reg;
    sfcb_calc_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // next values: both results are registered so downstream sees clean levels
    always_comb begin
        logic [8:0]  mult;
        logic [23:0] mant;
        mult = sfcb_pkg::DECIM_BASE + {7'h00, cfg.bw_m};
        mant = {15'h0000, sfcb_pkg::MANT_HIDDEN | {1'b0, cfg.rate_m}};
        state_next       = state_reg;
        // 8 * (4 + mantissa) * 2^exponent, at most 448 so nine bits suffice
        state_next.decim = (mult << sfcb_pkg::DECIM_SHIFT) << cfg.bw_e;  // [R5]
        // hidden ninth bit, then scale by 2^exponent; the 2^28 divide stays
        // implicit as the binary point of the rate accumulator downstream
        state_next.step  = mant << cfg.rate_e;                           // [R7]
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= '0;
        end else if (cen_i) begin
            state_reg <= state_next;
        end
    end

    assign cfg.decim_ratio = state_reg.decim;
    assign cfg.rate_step   = state_reg.step;
endmodule : sfcb_rate_calc

// ===== sfcb_regs.sv
// synthesiser base word and channel bandwidth / rate exponent register slice
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: top two bits of the high word byte always read back as 01.
// R2: low six bits of high byte hold word bits 21:16, reset 0x1E.
// R3: middle byte holds word bits 15:8, writable, reset 0xC4.
// R4: low byte holds word bits 7:0, writable, reset 0xEC.
// R5: bandwidth exponent 7:6 reset 10, mantissa 5:4 reset 00 set decimation.
// R6: symbol-rate exponent in bits 3:0, reset 1100, fed to rate generator.
// R7: rate step is (256 plus mantissa) shifted by exponent, over 2^28.
// R8: writes to the fixed high-byte bits are ignored; reads stay constant.
module sfcb_regs (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        cen_i,
    input  wire logic [5:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  symbol_rate_mantissa_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_rvalid_o,
    output logic      [23:0] synth_base_word_o,
    output logic      [1:0]  bandwidth_exponent_o,
    output logic      [1:0]  bandwidth_mantissa_o,
    output logic      [3:0]  symbol_rate_exponent_o,
    output logic      [8:0]  decimation_ratio_o,
    output logic      [23:0] symbol_rate_step_o
);
    typedef struct packed {
        logic [5:0] word_high;
        logic [7:0] word_middle;
        logic [7:0] word_low;
        logic [1:0] bw_e;
        logic [1:0] bw_m;
        logic [3:0] rate_e;
        logic [7:0] rdata;
        logic       rvalid;
    } sfcb_state_t;

    localparam sfcb_state_t RESET_STATE = '{
        word_high   : sfcb_pkg::HIGH_RESET,
        word_middle : sfcb_pkg::MIDDLE_RESET,
        word_low    : sfcb_pkg::LOW_RESET,
        bw_e        : sfcb_pkg::BW_E_RESET,
        bw_m        : sfcb_pkg::BW_M_RESET,
        rate_e      : sfcb_pkg::RATE_E_RESET,
        rdata       : 8'h00,
        rvalid      : 1'b0
    };

    sfcb_state_t state_reg;
    sfcb_state_t state_next;

    sfcb_cfg_if cfg ();

    ////////////////////////////////////////////////////////////////////////////
    // address compare, shared by the write and read paths
    function automatic logic addr_hit(input logic [5:0] addr,
                                      input logic [5:0] offset);
        addr_hit = (addr == offset);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    // register writes and registered read data
    always_comb begin
        state_next        = state_reg;
        state_next.rvalid = reg_rd_i;
        if (reg_wr_i) begin
            if (addr_hit(reg_addr_i, sfcb_pkg::OFF_HIGH)) begin
                // only the low six bits are storage; 7:6 are dropped on write
                state_next.word_high   = reg_wdata_i[5:0];            // [R2] [R8]
            end
            if (addr_hit(reg_addr_i, sfcb_pkg::OFF_MIDDLE)) begin
                state_next.word_middle = reg_wdata_i;                 // [R3]
            end
            if (addr_hit(reg_addr_i, sfcb_pkg::OFF_LOW)) begin
                state_next.word_low    = reg_wdata_i;                 // [R4]
            end
            if (addr_hit(reg_addr_i, sfcb_pkg::OFF_BW_RATE)) begin
                state_next.bw_e   = reg_wdata_i[sfcb_pkg::BW_E_LSB +: 2];   // [R5]
                state_next.bw_m   = reg_wdata_i[sfcb_pkg::BW_M_LSB +: 2];   // [R5]
                state_next.rate_e = reg_wdata_i[sfcb_pkg::RATE_E_LSB +: 4]; // [R6]
            end
        end
        // read returns the value held before any write in the same cycle
        state_next.rdata = 8'h00;                                     // unmapped reads zero
        if (reg_rd_i) begin
            if (addr_hit(reg_addr_i, sfcb_pkg::OFF_HIGH)) begin
                state_next.rdata = {sfcb_pkg::HIGH_FIXED, state_reg.word_high}; // [R1] [R8]
            end else if (addr_hit(reg_addr_i, sfcb_pkg::OFF_MIDDLE)) begin
                state_next.rdata = state_reg.word_middle;
            end else if (addr_hit(reg_addr_i, sfcb_pkg::OFF_LOW)) begin
                state_next.rdata = state_reg.word_low;
            end else if (addr_hit(reg_addr_i, sfcb_pkg::OFF_BW_RATE)) begin
                state_next.rdata = {state_reg.bw_e, state_reg.bw_m, state_reg.rate_e};
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= RESET_STATE;
        end else if (cen_i) begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fields handed to the rate calculator
    assign cfg.bw_e   = state_reg.bw_e;
    assign cfg.bw_m   = state_reg.bw_m;
    assign cfg.rate_e = state_reg.rate_e;                             // [R6]
    // mantissa lives in a neighbouring register outside this slice
    assign cfg.rate_m = symbol_rate_mantissa_i;

    sfcb_rate_calc u_rate_calc (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .cen_i  (cen_i),
        .cfg    (cfg.calc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all taken from flip-flops
    assign reg_rdata_o            = state_reg.rdata;
    assign reg_rvalid_o           = state_reg.rvalid;
    assign synth_base_word_o      = {sfcb_pkg::HIGH_FIXED, state_reg.word_high,
                                     state_reg.word_middle, state_reg.word_low}; // [R1]
    assign bandwidth_exponent_o   = state_reg.bw_e;
    assign bandwidth_mantissa_o   = state_reg.bw_m;
    assign symbol_rate_exponent_o = state_reg.rate_e;
    assign decimation_ratio_o     = cfg.decim_ratio;                  // [R5]
    assign symbol_rate_step_o     = cfg.rate_step;                    // [R7]
endmodule : sfcb_regs

// ===== sfcb_regs_monitor.sv
// port checker for the register slice
`timescale 1ns/1ps
module sfcb_regs_monitor (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        cen_i,
    input wire logic [5:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  symbol_rate_mantissa_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic [23:0] synth_base_word_o,
    input wire logic [1:0]  bandwidth_exponent_o,
    input wire logic [1:0]  bandwidth_mantissa_o,
    input wire logic [3:0]  symbol_rate_exponent_o,
    input wire logic [8:0]  decimation_ratio_o,
    input wire logic [23:0] symbol_rate_step_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic wr_en;
    assign wr_en = cen_i && reg_wr_i;
    ////////////////////////////////////////////////////////////////////////////////
    // each write lands on its own byte; derived terms lag the fields by one edge
    property p_fix; synth_base_word_o[23:22] == 2'h1; endproperty
    a_fix: assert property (p_fix) else $error("fixed word bits wrong");
    property p_hi; wr_en && reg_addr_i == 6'h0D |=> synth_base_word_o[21:16] == $past(reg_wdata_i[5:0]); endproperty
    a_hi: assert property (p_hi) else $error("high byte not written");
    property p_mid; wr_en && reg_addr_i == 6'h0E |=> synth_base_word_o[15:8] == $past(reg_wdata_i); endproperty
    a_mid: assert property (p_mid) else $error("middle byte not written");
    property p_low; wr_en && reg_addr_i == 6'h0F |=> synth_base_word_o[7:0] == $past(reg_wdata_i); endproperty
    a_low: assert property (p_low) else $error("low byte not written");
    property p_cfg; wr_en && reg_addr_i == 6'h10 |=> {bandwidth_exponent_o, bandwidth_mantissa_o, symbol_rate_exponent_o} == $past(reg_wdata_i); endproperty
    a_cfg: assert property (p_cfg) else $error("modem fields not written");
    property p_dec; cen_i |=> decimation_ratio_o == (9'h020 + 9'($past(bandwidth_mantissa_o)) * 9'h008) << $past(bandwidth_exponent_o); endproperty
    a_dec: assert property (p_dec) else $error("decimation ratio wrong");
    property p_step; cen_i |=> symbol_rate_step_o == 24'(9'h100 + 9'($past(symbol_rate_mantissa_i))) << $past(symbol_rate_exponent_o); endproperty
    a_step: assert property (p_step) else $error("rate step wrong");
    property p_rv; cen_i && reg_rd_i |=> reg_rvalid_o; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_idle; cen_i && !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outlived its cycle");
    property p_hird; cen_i && reg_rd_i && reg_addr_i == 6'h0D |=> reg_rdata_o[7:6] == 2'h1; endproperty
    a_hird: assert property (p_hird) else $error("fixed high bits not read back");
endmodule : sfcb_regs_monitor
bind sfcb_regs sfcb_regs_monitor mon (.clk_i(clk_i), .rstn_i(rstn_i), .cen_i(cen_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .symbol_rate_mantissa_i(symbol_rate_mantissa_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .synth_base_word_o(synth_base_word_o),
    .bandwidth_exponent_o(bandwidth_exponent_o), .bandwidth_mantissa_o(bandwidth_mantissa_o),
    .symbol_rate_exponent_o(symbol_rate_exponent_o), .decimation_ratio_o(decimation_ratio_o),
    .symbol_rate_step_o(symbol_rate_step_o));

// ===== sfcb_host.sv
// host model driving the register port
`timescale 1ns/1ps
module sfcb_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic      [5:0] addr_o,
    output logic            wr_o,
    output logic      [7:0] wdata_o,
    output logic            rd_o
);
    // answer seen in the one cycle that it stands: {rvalid, rdata}
    logic [8:0] last_q;
    initial begin
        last_q = 9'h000;
        addr_o = 6'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    // one strobe cycle, then an idle cycle; idle lines scrambled so stale values never match
    task automatic access(input logic [5:0] a, input logic [7:0] d, input logic w);
        addr_o = a;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(posedge clk_i);
        #1;
        // read answer stands only until the next edge, so take it here
        last_q = {rvalid_i, rdata_i};
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
        @(posedge clk_i);
        #1;
    endtask : access
endmodule : sfcb_host

// ===== sfcb_regs_bench.sv
// self-checking bench for the register slice
`timescale 1ns/1ps
module sfcb_regs_bench;
    logic       clk_i, rstn_i, cen_i, wr, rd;
    logic [5:0] addr;
    logic [7:0] wdata, mant;
    logic [1:0] k;
    logic [7:0] rdata;
    logic       rvalid;
    int         n_fail = 0;
    int         compares = 0;
    logic [5:0] ra [6] = '{6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h0C, 6'h3F};
    logic [7:0] rv [6] = '{8'h5E, 8'hC4, 8'hEC, 8'h8C, 8'h00, 8'h00};
    sfcb_host host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
        .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
    sfcb_regs uut (.clk_i(clk_i), .rstn_i(rstn_i), .cen_i(cen_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .symbol_rate_mantissa_i(mant),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .synth_base_word_o(), .bandwidth_exponent_o(),
        .bandwidth_mantissa_o(), .symbol_rate_exponent_o(), .decimation_ratio_o(),
        .symbol_rate_step_o());
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        host.access(a, 8'h00, 1'b0);
        chk("rdata", {15'h0000, host.last_q}, {16'h0001, e});
    endtask : rd_chk
    task automatic final_report();
        if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // reset values, field writes, derived terms, then a frozen write
    initial begin
        cen_i = 1'b1;
        mant = 8'h22;
        rstn_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        chk("word", uut.synth_base_word_o, 24'h5E_C4EC);
        for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i]);
        chk("decim", 24'(uut.decimation_ratio_o), 24'h00_0080);
        chk("step", uut.symbol_rate_step_o, 24'h12_2000);
        host.access(6'h0D, 8'hFF, 1'b1);
        rd_chk(6'h0D, 8'h7F);
        host.access(6'h0E, 8'h12, 1'b1);
        host.access(6'h0F, 8'h34, 1'b1);
        chk("word", uut.synth_base_word_o, 24'h7F_1234);
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            mant = 8'(i * 85);
            host.access(6'h10, {k, ~k, 2'b00, k}, 1'b1);
            chk("decim", 24'(uut.decimation_ratio_o), 24'((32 + 8 * (3 - i)) << i));
            chk("step", uut.symbol_rate_step_o, 24'(9'h100 + 9'(mant)) << k);
            chk("fields", {16'h0000, uut.bandwidth_exponent_o, uut.bandwidth_mantissa_o,
                uut.symbol_rate_exponent_o}, {16'h0000, k, ~k, 2'b00, k});
            rd_chk(6'h10, {k, ~k, 2'b00, k});
        end
        cen_i = 1'b0;
        host.access(6'h0E, 8'hAA, 1'b1);
        cen_i = 1'b1;
        rd_chk(6'h0E, 8'h12);
        final_report();
    end
    initial begin
        #50000;
        n_fail++;
        final_report();
    end
endmodule : sfcb_regs_bench
